// ---- design/rmaf_top.sv ----
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// reading median and average filter top
// ****************************************************************
module rmaf_top (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [rmaf_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [rmaf_pkg::REG_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [rmaf_pkg::REG_W-1:0] reg_rdata_o,
  // measurement events
  input wire logic zero_check_i,
  input wire logic [2:0] range_sel_i,
  input wire logic damping_toggle_i,
  // readings from the converter
  input wire logic reading_valid_i,
  input wire logic [rmaf_pkg::DATA_W-1:0] reading_i,
  output logic reading_ready_o,
  // filtered readings
  output logic filter_indicator_valid_o,
  output logic [rmaf_pkg::DATA_W-1:0] filter_indicator_data_o,
  // indicators
  output logic filter_indicator_o,
  output logic damping_o
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int DW = rmaf_pkg::DATA_W;
  localparam int SW = rmaf_pkg::SUM_W;
  logic [3:0] ctrl_q; // enables, type, damping
  logic [2:0] rank_q; // median rank
  logic [6:0] count_q; // averaging count
  logic [2:0] range_q; // last seen range
  logic restart; // histories start over
  logic cfg_wr; // filter setting rewritten
  rmaf_pkg::rmaf_state_t state_q; // engine state
  logic signed [DW-1:0] cur_q; // reading in flight
  logic signed [DW-1:0] stack_q [rmaf_pkg::AVG_MAX]; // moving stack
  logic signed [SW-1:0] sum_q; // running sum
  logic [6:0] held_q; // readings in stack
  logic [SW-1:0] dvd_q; // dividend, becomes quotient
  logic [7:0] rem_q; // partial remainder
  logic [6:0] dvs_q; // divisor
  logic neg_q; // sum was negative
  logic [5:0] step_q; // divider step
  logic med_en;
  logic avg_en;
  logic moving;
  logic take;
  logic avg_push;
  logic full;
  logic div_go;
  logic div_last;
  logic signed [SW-1:0] sum_next;
  logic [6:0] held_next;
  logic [7:0] trial;
  logic fit;
  logic [SW-1:0] quot;
  logic [rmaf_pkg::REG_W-1:0] rd_val;
  // ****************************************************************
  // helpers
  // ****************************************************************
  // limit a written value to its legal span
  function automatic logic [7:0] clamp(input logic [7:0] v,
                                       input logic [7:0] lo,
                                       input logic [7:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  // widen a reading to the sum width
  function automatic logic signed [SW-1:0] widen(input logic signed [DW-1:0] v);
    widen = SW'(v);
  endfunction
  // ****************************************************************
  // sub-blocks
  // ****************************************************************
  rmaf_stream_if fifo_out_if ();
  rmaf_stream_if med_in_if ();
  rmaf_stream_if med_out_if ();
  logic med_done;
  // input buffer toward the converter
  rmaf_fifo #(
    .WIDTH(rmaf_pkg::DATA_W),
    .DEPTH(rmaf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .flush_i(restart),
    .in_valid_i(reading_valid_i),
    .in_data_i(reading_i),
    .in_ready_o(reading_ready_o),
    .out(fifo_out_if.src)
  );
  // moving median stage
  rmaf_median u_median (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .clear_i(restart),
    .rank_i(rank_q),
    .in(med_in_if.snk),
    .out(med_out_if.src),
    .done_o(med_done)
  );
  // ****************************************************************
  // configuration registers
  // ****************************************************************
  assign med_en = ctrl_q[rmaf_pkg::CTRL_MED_BIT];
  assign avg_en = ctrl_q[rmaf_pkg::CTRL_AVG_BIT];
  assign moving = !ctrl_q[rmaf_pkg::CTRL_TYPE_BIT];
  // rewriting rank or count, or changing the filter mode, restarts the histories
  assign cfg_wr = reg_write_i && ((reg_addr_i == rmaf_pkg::OFF_RANK)
                  || (reg_addr_i == rmaf_pkg::OFF_COUNT)
                  || ((reg_addr_i == rmaf_pkg::OFF_CTRL)
                      && (reg_wdata_i[2:0] != ctrl_q[2:0])));
  // zero check or a range change empties both stages
  assign restart = zero_check_i || (range_sel_i != range_q) || cfg_wr;
  // control register with damping key toggle
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      ctrl_q <= rmaf_pkg::CTRL_RESET;
    else if (reg_write_i && reg_addr_i == rmaf_pkg::OFF_CTRL)
      ctrl_q <= reg_wdata_i[3:0];
    else if (damping_toggle_i)
      ctrl_q[rmaf_pkg::CTRL_DAMPING_TOGGLE_BIT] <= !ctrl_q[rmaf_pkg::CTRL_DAMPING_TOGGLE_BIT];
  end
  // median rank, held to its legal span
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      rank_q <= rmaf_pkg::RANK_RESET;
    else if (reg_write_i && reg_addr_i == rmaf_pkg::OFF_RANK)
      rank_q <= 3'(clamp(reg_wdata_i[7:0], rmaf_pkg::RANK_MIN, rmaf_pkg::RANK_MAX));
  end
  // averaging count, held to its legal span
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      count_q <= rmaf_pkg::COUNT_RESET;
    else if (reg_write_i && reg_addr_i == rmaf_pkg::OFF_COUNT)
      count_q <= 7'(clamp(reg_wdata_i[7:0], rmaf_pkg::COUNT_MIN, rmaf_pkg::COUNT_MAX));
  end
  // range tracker; settings are not banked per range
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      range_q <= '0;
    else
      range_q <= range_sel_i;
  end
  // ****************************************************************
  // register read port
  // ****************************************************************
  // read mux; unmapped offsets read zero
  always_comb
  begin
    rd_val = '0;
    case (reg_addr_i)
      rmaf_pkg::OFF_CTRL: rd_val[3:0] = ctrl_q;
      rmaf_pkg::OFF_RANK: rd_val[2:0] = rank_q;
      rmaf_pkg::OFF_COUNT: rd_val[6:0] = count_q;
      rmaf_pkg::OFF_STATUS:
      begin
        rd_val[rmaf_pkg::STAT_IND_BIT] = filter_indicator_o;
        rd_val[rmaf_pkg::STAT_BUSY_BIT] = (state_q != rmaf_pkg::ST_IDLE);
        rd_val[rmaf_pkg::STAT_HELD_LSB +: 7] = held_q;
      end
      default: rd_val = '0;
    endcase
  end
  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      reg_rdata_o <= '0;
    else
      reg_rdata_o <= reg_read_i ? rd_val : '0;
  end
  // ****************************************************************
  // engine control
  // ****************************************************************
  // take from the fifo only when idle and the median can accept
  assign fifo_out_if.ready = (state_q == rmaf_pkg::ST_IDLE) && !restart
                             && (!med_en || med_in_if.ready);
  assign take = fifo_out_if.valid && fifo_out_if.ready;
  assign med_in_if.valid = take && med_en;
  assign med_in_if.data = fifo_out_if.data;
  assign med_out_if.ready = 1'b1;
  // state sequence per reading
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      state_q <= rmaf_pkg::ST_IDLE;
    else if (restart)
      state_q <= rmaf_pkg::ST_IDLE;
    else
      case (state_q)
        rmaf_pkg::ST_IDLE:
          if (take)
            state_q <= med_en ? rmaf_pkg::ST_MED : rmaf_pkg::ST_AVG;
        rmaf_pkg::ST_MED:
          // wait for the median stage; no result while it fills
          if (med_done)
            state_q <= med_out_if.valid ? rmaf_pkg::ST_AVG : rmaf_pkg::ST_IDLE;
        rmaf_pkg::ST_AVG:
          state_q <= div_go ? rmaf_pkg::ST_DIV : rmaf_pkg::ST_IDLE;
        rmaf_pkg::ST_DIV:
          if (div_last)
            state_q <= rmaf_pkg::ST_IDLE;
        default:
          state_q <= rmaf_pkg::ST_IDLE;
      endcase
  end
  // reading in flight: raw, or the median result
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
      cur_q <= '0;
    else if (take && !med_en)
      cur_q <= fifo_out_if.data;
    else if (state_q == rmaf_pkg::ST_MED && med_out_if.valid)
      cur_q <= med_out_if.data;
  end
  // ****************************************************************
  // averaging stack
  // ****************************************************************
  assign avg_push = (state_q == rmaf_pkg::ST_AVG) && avg_en && !restart;
  assign full = (held_q == count_q);
  // next sum and fill; a full moving stack drops its oldest entry
  always_comb
  begin
    if (moving && full)
    begin
      sum_next = sum_q + widen(cur_q) - widen(stack_q[count_q - 7'h01]);
      held_next = held_q;
    end
    else
    begin
      sum_next = sum_q + widen(cur_q);
      held_next = held_q + 7'h01;
    end
  end
  // moving mode divides every time, repeating only when complete
  assign div_go = avg_push && (moving || held_next == count_q);
  // stack shift, newest at index 0
  always_ff @(posedge core_clk_i)
  begin
    if (avg_push && moving)
    begin
      stack_q[0] <= cur_q;
      for (int k = 1; k < rmaf_pkg::AVG_MAX; k++)
        stack_q[k] <= stack_q[k-1];
    end
  end
  // running sum and fill level
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sum_q <= '0;
      held_q <= '0;
    end
    else if (restart)
    begin
      sum_q <= '0;
      held_q <= '0;
    end
    else if (avg_push && !moving && div_go)
    begin
      sum_q <= '0;
      held_q <= '0;
    end
    else if (avg_push)
    begin
      sum_q <= sum_next;
      held_q <= held_next;
    end
  end
  // ****************************************************************
  // divider
  // ****************************************************************
  assign trial = {rem_q[6:0], dvd_q[SW-1]};
  assign fit = (trial >= {1'b0, dvs_q});
  assign quot = {dvd_q[SW-2:0], fit};
  assign div_last = (state_q == rmaf_pkg::ST_DIV) && (step_q == rmaf_pkg::DIV_STEPS - 6'h01);
  // restoring division of the sum magnitude, one bit a cycle
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      dvd_q <= '0;
      rem_q <= '0;
      dvs_q <= '0;
      neg_q <= 1'b0;
      step_q <= '0;
    end
    else if (div_go)
    begin
      dvd_q <= sum_next[SW-1] ? SW'(-sum_next) : SW'(sum_next);
      neg_q <= sum_next[SW-1];
      dvs_q <= moving ? held_next : count_q;
      rem_q <= '0;
      step_q <= '0;
    end
    else if (state_q == rmaf_pkg::ST_DIV)
    begin
      dvd_q <= quot;
      rem_q <= fit ? (trial - {1'b0, dvs_q}) : trial;
      step_q <= step_q + 6'h01;
    end
  end
  // ****************************************************************
  // outputs
  // ****************************************************************
  // filtered reading: bypass when averaging is off, else the mean
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      filter_indicator_valid_o <= 1'b0;
      filter_indicator_data_o <= '0;
    end
    else
    begin
      filter_indicator_valid_o <= 1'b0;
      if (state_q == rmaf_pkg::ST_AVG && !avg_en && !restart)
      begin
        filter_indicator_valid_o <= 1'b1;
        filter_indicator_data_o <= cur_q;
      end
      else if (div_last && !restart)
      begin
        filter_indicator_valid_o <= 1'b1;
        filter_indicator_data_o <= neg_q ? DW'(-quot) : DW'(quot);
      end
    end
  end
  // shared indicator and damping level
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      filter_indicator_o <= 1'b0;
      damping_o <= 1'b0;
    end
    else
    begin
      filter_indicator_o <= med_en || avg_en || ctrl_q[rmaf_pkg::CTRL_DAMPING_TOGGLE_BIT];
      damping_o <= ctrl_q[rmaf_pkg::CTRL_DAMPING_TOGGLE_BIT];
    end
  end
endmodule // rmaf_top
`default_nettype wire

// ---- inc/rmaf_pkg.sv ----
// ****************************************************************
// reading filter shared constants
// ****************************************************************
package rmaf_pkg;
  // data path widths and depths
  localparam int DATA_W = 24;
  localparam int SUM_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int MED_MAX = 11;
  localparam int AVG_MAX = 100;
  localparam int ADDR_W = 4;
  localparam int REG_W = 32;
  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_RANK = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hC;
  // control register fields
  localparam int CTRL_MED_BIT = 0;
  localparam int CTRL_AVG_BIT = 1;
  localparam int CTRL_TYPE_BIT = 2;
  localparam int CTRL_DAMPING_TOGGLE_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h8;
  // median rank and averaging count limits
  localparam logic [7:0] RANK_MIN = 8'h01;
  localparam logic [7:0] RANK_MAX = 8'h05;
  localparam logic [2:0] RANK_RESET = 3'h1;
  localparam logic [7:0] COUNT_MIN = 8'h02;
  localparam logic [7:0] COUNT_MAX = 8'h64;
  localparam logic [6:0] COUNT_RESET = 7'h0A;
  // status register fields
  localparam int STAT_IND_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_HELD_LSB = 16;
  // divider step count
  localparam logic [5:0] DIV_STEPS = 6'h20;
  // engine states
  typedef enum logic [2:0] {ST_IDLE, ST_MED, ST_AVG, ST_DIV} rmaf_state_t;
endpackage

// ---- inc/rmaf_stream_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// reading stream between filter modules
// ****************************************************************
interface rmaf_stream_if;
  logic valid; // source holds a reading
  logic ready; // sink takes it this cycle
  logic signed [rmaf_pkg::DATA_W-1:0] data; // reading value
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- design/rmaf_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// reading input fifo
// ****************************************************************
module rmaf_fifo #(
  parameter int WIDTH = rmaf_pkg::DATA_W,
  parameter int DEPTH = rmaf_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // drop all held readings
  input wire logic flush_i,
  // filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // draining side
  rmaf_stream_if.src out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
  logic [AW-1:0] wr_ptr_q; // next write slot
  logic [AW-1:0] rd_ptr_q; // oldest word
  logic [AW:0] count_q; // words held
  logic [AW:0] count_d;
  logic push;
  logic pop;
  assign push = in_valid_i && in_ready_o;
  assign pop = out.valid && out.ready;
  assign out.valid = (count_q != '0);
  assign out.data = mem_q[rd_ptr_q];
  assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
  // storage write
  always_ff @(posedge core_clk_i)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data_i;
  end
  // pointers, fill level and registered ready
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready_o <= 1'b0;
    end
    else if (flush_i)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_q + AW'(push);
      rd_ptr_q <= rd_ptr_q + AW'(pop);
      count_q <= count_d;
      in_ready_o <= (count_d != DEPTH[AW:0]);
    end
  end
endmodule // rmaf_fifo
`default_nettype wire

// ---- design/rmaf_median.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// moving median stage
// ****************************************************************
module rmaf_median (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // restart and window size
  input wire logic clear_i,
  input wire logic [2:0] rank_i,
  // readings in, medians out
  rmaf_stream_if.snk in,
  rmaf_stream_if.src out,
  output logic done_o
);
  localparam int MAX = rmaf_pkg::MED_MAX;
  logic signed [rmaf_pkg::DATA_W-1:0] win_q [MAX]; // newest at index 0
  logic [3:0] fill_q; // readings held
  logic calc_q; // median due this cycle
  logic [3:0] n_win; // window length
  logic [3:0] pos;
  logic signed [rmaf_pkg::DATA_W-1:0] med_val;
  // ordering with ties broken by position
  function automatic logic precedes(input logic signed [rmaf_pkg::DATA_W-1:0] a,
                                    input logic signed [rmaf_pkg::DATA_W-1:0] b,
                                    input logic earlier);
    precedes = (a < b) || ((a == b) && earlier);
  endfunction
  assign n_win = {rank_i, 1'b1};
  assign in.ready = !calc_q;
  // pick the entry with exactly rank entries below it
  always_comb
  begin
    med_val = '0;
    pos = '0;
    for (int i = 0; i < MAX; i++)
    begin
      pos = '0;
      for (int j = 0; j < MAX; j++)
        if (j != i && j < n_win && precedes(win_q[j], win_q[i], j < i))
          pos = pos + 4'h1;
      if (i < n_win && pos == {1'b0, rank_i})
        med_val = win_q[i];
    end
  end
  // window shift: oldest falls off the end
  always_ff @(posedge core_clk_i)
  begin
    if (in.valid && in.ready)
    begin
      win_q[0] <= in.data;
      for (int k = 1; k < MAX; k++)
        win_q[k] <= win_q[k-1];
    end
  end
  // fill level, result and done pulse
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      fill_q <= '0;
      calc_q <= 1'b0;
      done_o <= 1'b0;
      out.valid <= 1'b0;
      out.data <= '0;
    end
    else if (clear_i)
    begin
      fill_q <= '0;
      calc_q <= 1'b0;
      done_o <= 1'b0;
      out.valid <= 1'b0;
    end
    else
    begin
      done_o <= calc_q;
      out.valid <= calc_q && (fill_q == n_win);
      if (calc_q)
        out.data <= med_val;
      calc_q <= in.valid && in.ready;
      if (in.valid && in.ready && fill_q != n_win)
        fill_q <= fill_q + 4'h1;
    end
  end
endmodule // rmaf_median
`default_nettype wire

// ---- verification/rmaf_top_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port checker for the reading filter
// ****************************************************************
module rmaf_top_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [rmaf_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [rmaf_pkg::REG_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [rmaf_pkg::REG_W-1:0] reg_rdata_o,
  // events and stream
  input wire logic damping_toggle_i,
  input wire logic reading_valid_i,
  input wire logic reading_ready_o,
  input wire logic filter_indicator_valid_o,
  // indicators
  input wire logic filter_indicator_o,
  input wire logic damping_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // readings taken and results released since reset
  logic [15:0] takes_q;
  logic [15:0] outs_q;
  // count both sides of the stream
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      takes_q <= '0;
      outs_q <= '0;
    end
    else
    begin
      takes_q <= takes_q + 16'(reading_valid_i && reading_ready_o);
      outs_q <= outs_q + 16'(filter_indicator_valid_o);
    end
  end
  // no write and no key press in a cycle
  sequence s_quiet;
    !reg_write_i && !damping_toggle_i;
  endsequence
  // software write to the control word
  sequence s_ctrl_wr;
    reg_write_i && reg_addr_i == rmaf_pkg::OFF_CTRL;
  endsequence
  // key press without a competing write
  sequence s_toggle;
    damping_toggle_i && !reg_write_i;
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_read_i) |-> reg_rdata_o == '0)
    else $error("read data not zero outside read answer");
  a_damping_toggle_key_flips: assert property (s_toggle ##1 s_quiet |=> damping_o != $past(damping_o))
    else $error("damping key did not flip flag");
  a_damping_toggle_write_sets: assert property (s_ctrl_wr ##1 s_quiet |=>
    damping_o == $past(reg_wdata_i[rmaf_pkg::CTRL_DAMPING_TOGGLE_BIT], 2))
    else $error("damping flag differs from written bit");
  a_ind_from_ctrl: assert property (s_ctrl_wr ##1 s_quiet |=>
    filter_indicator_o == |($past(reg_wdata_i[3:0], 2) & 4'hB))
    else $error("indicator differs from enables");
  a_ind_with_damping_toggle: assert property (damping_o |-> filter_indicator_o)
    else $error("indicator low while damping on");
  a_reset_defaults: assert property ($past(reset_i, 2) && !$past(reset_i) |->
    damping_o && filter_indicator_o && reading_ready_o)
    else $error("outputs wrong after reset release");
  a_out_needs_in: assert property (outs_q <= takes_q)
    else $error("more results than readings");
  a_valid_one_cycle: assert property (filter_indicator_valid_o |=> !filter_indicator_valid_o)
    else $error("result valid longer than one cycle");
endmodule // rmaf_top_props
bind rmaf_top rmaf_top_props u_props (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i,
  .reg_write_i, .reg_read_i, .reg_rdata_o, .damping_toggle_i, .reading_valid_i,
  .reading_ready_o, .filter_indicator_valid_o, .filter_indicator_o, .damping_o);
`default_nettype wire

// ---- verification/rmaf_conv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// converter model feeding readings
// ****************************************************************
module rmaf_conv_model (
  // clock
  input wire logic core_clk_i,
  // reading handshake
  input wire logic ready_i,
  output logic valid_o,
  output logic [rmaf_pkg::DATA_W-1:0] data_o
);
  int stalls = 0; // cycles refused by the filter
  bit hung = 1'b0; // a reading was never taken
  initial valid_o = 1'b0;
  initial data_o = '0;
  // offer one reading and hold it until taken or 300 cycles pass
  task automatic send(input logic [rmaf_pkg::DATA_W-1:0] d);
    logic r;
    int n;
    r = 1'b0;
    n = 0;
    @(posedge core_clk_i);
    valid_o <= 1'b1;
    data_o <= d;
    while (!r && n < 300)
    begin
      @(negedge core_clk_i);
      r = ready_i;
      stalls += int'(!r);
      n++;
      @(posedge core_clk_i);
    end
    hung |= !r;
    // released data line shows the inverse, not the old value
    valid_o <= 1'b0;
    data_o <= ~d;
  endtask
endmodule // rmaf_conv_model
`default_nettype wire

// ---- verification/rmaf_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// reading filter testbench
// ****************************************************************
module rmaf_top_tb;
  // stimulus
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [rmaf_pkg::ADDR_W-1:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic zero_check_i = 1'b0;
  logic [2:0] range_sel_i = '0;
  logic damping_toggle_i = 1'b0;
  logic reading_valid_i;
  logic [23:0] reading_i;
  // observed outputs
  logic [31:0] reg_rdata_o;
  logic reading_ready_o;
  logic filter_indicator_valid_o;
  logic [23:0] filter_indicator_data_o;
  logic filter_indicator_o;
  logic damping_o;
  // bookkeeping
  int miscompares = 0;
  int total_checks = 0;
  logic [31:0] got[$];
  int fi[$];
  int fo[$];
  always #2.5 core_clk_i = ~core_clk_i;
  rmaf_top dut (.core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_write_i,
    .reg_read_i, .reg_rdata_o, .zero_check_i, .range_sel_i, .damping_toggle_i,
    .reading_valid_i, .reading_i, .reading_ready_o, .filter_indicator_valid_o, .filter_indicator_data_o,
    .filter_indicator_o, .damping_o);
  rmaf_conv_model conv (.core_clk_i, .ready_i(reading_ready_o), .valid_o(reading_valid_i),
    .data_o(reading_i));
  // collect every released result, sign extended
  always @(posedge core_clk_i)
    if (filter_indicator_valid_o === 1'b1) got.push_back({{8{filter_indicator_data_o[23]}}, filter_indicator_data_o});
  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic conclude;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_write_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask
  // one-cycle register read, data in the following cycle
  task automatic rdchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1 check(nm, reg_rdata_o, e);
  endtask
  // configure, feed readings with an optional restart, compare results
  task automatic scen(input logic [3:0] c, input logic [7:0] rk, input logic [7:0] cn,
                      input int ev, input int di[$], input int dq[$]);
    int n;
    wr(rmaf_pkg::OFF_COUNT, 32'(cn));
    wr(rmaf_pkg::OFF_RANK, 32'(rk));
    wr(rmaf_pkg::OFF_CTRL, 32'(c));
    got.delete();
    foreach (di[i])
    begin
      if (i == 2 && ev == 1)
      begin
        @(posedge core_clk_i) zero_check_i <= 1'b1;
        @(posedge core_clk_i) zero_check_i <= 1'b0;
      end
      if (i == 2 && ev == 2) @(posedge core_clk_i) range_sel_i <= range_sel_i + 3'h1;
      conv.send(24'(di[i]));
      if (conv.hung)
      begin
        miscompares++;
        conclude;
      end
    end
    n = 0;
    while (got.size() < dq.size() && n < 800)
    begin
      @(posedge core_clk_i);
      n++;
    end
    if (n == 800)
    begin
      miscompares++;
      conclude;
    end
    // quiet spell so that surplus results show up
    repeat (40) @(posedge core_clk_i);
    check("result count", 32'(got.size()), 32'(dq.size()));
    foreach (dq[i]) if (i < got.size()) check("result", got[i], 32'(dq[i]));
    check("indicator", 32'(filter_indicator_o), 32'(|(c & 4'hB)));
  endtask
  // main sequence
  initial
  begin
    repeat (6) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rdchk("control", rmaf_pkg::OFF_CTRL, 32'h0000_0008);
    rdchk("rank", rmaf_pkg::OFF_RANK, 32'h0000_0001);
    rdchk("count", rmaf_pkg::OFF_COUNT, 32'h0000_000A);
    rdchk("unmapped", 4'h2, 32'h0000_0000);
    check("damping", 32'(damping_o), 32'h0000_0001);
    wr(rmaf_pkg::OFF_RANK, 32'h0000_0007);
    rdchk("rank high", rmaf_pkg::OFF_RANK, 32'h0000_0005);
    wr(rmaf_pkg::OFF_RANK, 32'h0000_0000);
    rdchk("rank low", rmaf_pkg::OFF_RANK, 32'h0000_0001);
    wr(rmaf_pkg::OFF_COUNT, 32'h0000_0065);
    rdchk("count high", rmaf_pkg::OFF_COUNT, 32'h0000_0064);
    wr(rmaf_pkg::OFF_COUNT, 32'h0000_0001);
    rdchk("count low", rmaf_pkg::OFF_COUNT, 32'h0000_0002);
    scen(4'h0, 8'h01, 8'h0A, 0, '{5, -2}, '{5, -2});
    scen(4'h1, 8'h02, 8'h0A, 0, '{9, 1, 8, 2, 7, 3}, '{7, 3});
    scen(4'h1, 8'h05, 8'h0A, 0, '{11, 1, 10, 2, 9, 3, 8, 4, 7, 5, 6, 0}, '{6, 5});
    scen(4'h1, 8'h01, 8'h0A, 1, '{5, 6, 1, 2, 3, 4}, '{2, 3});
    scen(4'h2, 8'h01, 8'h03, 0, '{-3, -6, -8, 12}, '{-3, -4, -5, 0});
    rdchk("status", rmaf_pkg::OFF_STATUS, 32'h0003_0001);
    scen(4'h6, 8'h01, 8'h03, 2, '{50, 60, 1, 2, 4, 10, 20, 30}, '{2, 20});
    scen(4'h3, 8'h01, 8'h02, 0, '{1, 5, 3, 7}, '{3, 4});
    // burst against a slow averaging engine fills the input buffer
    for (int i = 0; i < 20; i++)
    begin
      fi.push_back(2 * i);
      fo.push_back(i == 0 ? 0 : 2 * i - 1);
    end
    scen(4'hA, 8'h01, 8'h02, 0, fi, fo);
    check("buffer refused", 32'(conv.stalls > 0), 32'h0000_0001);
    wr(rmaf_pkg::OFF_CTRL, 32'h0000_0000);
    @(posedge core_clk_i) damping_toggle_i <= 1'b1;
    @(posedge core_clk_i) damping_toggle_i <= 1'b0;
    rdchk("toggled control", rmaf_pkg::OFF_CTRL, 32'h0000_0008);
    check("toggled damping", 32'(damping_o), 32'h0000_0001);
    check("toggled indicator", 32'(filter_indicator_o), 32'h0000_0001);
    conclude;
  end
endmodule // rmaf_top_tb
`default_nettype wire
